// ---- verilog/hu_device.sv ----
// hu_device: serial engine and the device end of the host port
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`default_nettype none
module hu_serial
(
	// clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_clr,
	// settings
	input  wire logic [15:0]          i_div,
	input  wire hu_pkg::hu_frame_type i_cfg,
	// transmit
	input  wire logic [7:0]           i_tx_data,
	input  wire logic                 i_tx_go,
	output logic                      o_txd,
	output logic                      o_tx_busy,
	// receive, line already synchronised
	input  wire logic                 i_rxd,
	output logic [7:0]                o_rx_data,
	output logic                      o_rx_done,
	output logic                      o_par_err,
	output logic                      o_frm_err
);
	import hu_pkg::*;
	hu_bit_state_type tx_st;
	hu_bit_state_type rx_st;
	logic [15:0]      tx_cnt;
	logic [15:0]      rx_cnt;
	logic [2:0]       tx_idx;
	logic [2:0]       rx_idx;
	logic [7:0]       tx_sh;
	logic [7:0]       rx_sh;
	logic             tx_par;
	logic             rx_par;
	logic             rx_perr;
	logic             tx_stop2nd;
	logic [2:0]       last_idx;
	assign last_idx = 3'(i_cfg.len) + 3'h4;

	// transmitter: start low, data lsb first, parity, stops
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tx_st <= HU_IDLE;
			tx_cnt <= 16'h0000;
			tx_idx <= 3'h0;
			tx_sh <= 8'h00;
			tx_par <= 1'b0;
			tx_stop2nd <= 1'b0;
			o_txd <= 1'b1;
			o_tx_busy <= 1'b0;
		end
		else if (i_clr)
		begin
			tx_st <= HU_IDLE;
			o_txd <= 1'b1;
			o_tx_busy <= 1'b0;
		end
		else if (tx_st == HU_IDLE)
		begin
			if (i_tx_go)
			begin
				tx_sh <= i_tx_data;
				tx_par <= i_cfg.par_odd;
				tx_cnt <= i_div;
				tx_st <= HU_START;
				o_txd <= 1'b0;
				o_tx_busy <= 1'b1;
			end
		end
		else if (tx_cnt != 16'h0000)
			tx_cnt <= tx_cnt - 16'h0001;
		else
		begin
			tx_cnt <= i_div;
			case (tx_st)
				HU_START, HU_DATA:
				begin
					if (tx_st == HU_DATA && tx_idx == last_idx)
					begin
						tx_stop2nd <= 1'b0;
						tx_st <= i_cfg.par_en ? HU_PARITY : HU_STOP;
						o_txd <= i_cfg.par_en ? tx_par : 1'b1;
					end
					else
					begin
						o_txd <= tx_sh[0];
						tx_par <= tx_par ^ tx_sh[0];
						tx_sh <= {1'b0, tx_sh[7:1]};
						tx_idx <= (tx_st == HU_START) ? 3'h0 : tx_idx + 3'h1;
						tx_st <= HU_DATA;
					end
				end
				HU_PARITY:
				begin
					o_txd <= 1'b1;
					tx_st <= HU_STOP;
				end
				default:
				begin
					// second stop bit only when configured
					if (i_cfg.stop2 && !tx_stop2nd)
						tx_stop2nd <= 1'b1;
					else
					begin
						tx_st <= HU_IDLE;
						o_tx_busy <= 1'b0;
					end
				end
			endcase
		end
	end

	// receiver samples mid-bit; one stop bit is checked, a second is idle time
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_st <= HU_IDLE;
			rx_cnt <= 16'h0000;
			rx_idx <= 3'h0;
			rx_sh <= 8'h00;
			rx_par <= 1'b0;
			rx_perr <= 1'b0;
			o_rx_data <= 8'h00;
			o_rx_done <= 1'b0;
			o_par_err <= 1'b0;
			o_frm_err <= 1'b0;
		end
		else
		begin
			o_rx_done <= 1'b0;
			if (i_clr)
				rx_st <= HU_IDLE;
			else if (rx_st == HU_IDLE)
			begin
				if (!i_rxd)
				begin
					rx_cnt <= {1'b0, i_div[15:1]};
					rx_st <= HU_START;
				end
			end
			else if (rx_cnt != 16'h0000)
				rx_cnt <= rx_cnt - 16'h0001;
			else
			begin
				rx_cnt <= i_div;
				case (rx_st)
					HU_START:
					begin
						// a start bit gone high by mid-bit was a glitch
						rx_st <= i_rxd ? HU_IDLE : HU_DATA;
						rx_idx <= 3'h0;
						rx_par <= i_cfg.par_odd;
						rx_perr <= 1'b0;
					end
					HU_DATA:
					begin
						rx_sh <= {i_rxd, rx_sh[7:1]};
						rx_par <= rx_par ^ i_rxd;
						rx_idx <= rx_idx + 3'h1;
						if (rx_idx == last_idx)
							rx_st <= i_cfg.par_en ? HU_PARITY : HU_STOP;
					end
					HU_PARITY:
					begin
						rx_perr <= i_rxd ^ rx_par;
						rx_st <= HU_STOP;
					end
					default:
					begin
						o_rx_data <= rx_sh >> (3'h3 - 3'(i_cfg.len));
						o_rx_done <= 1'b1;
						o_par_err <= rx_perr;
						o_frm_err <= !i_rxd;
						rx_st <= HU_IDLE;
					end
				endcase
			end
		end
	end
endmodule

module hu_device
#(
	parameter int unsigned LF_DIV = hu_pkg::LF_DIV_CYC,
	parameter int unsigned RST_TICKS = hu_pkg::RST_DLY_TICKS,
	parameter int unsigned BLINK = hu_pkg::BLINK_TICKS
)
(
	// clock and power-on reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// ahb-lite slave
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic [31:0]      o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	// internal reset sources
	input  wire logic        i_watchdog_reset,
	input  wire logic        i_low_voltage_reset,
	input  wire logic        i_core_system_reset_request,
	input  wire logic        i_whole_chip_soft_reset,
	output logic             o_sys_reset,
	// radio link side
	input  wire logic        i_link_up,
	output logic             o_link_drop,
	output logic             o_transfer_mode_select,
	output logic             o_irq,
	// pins toward the host
	hu_link_if.dev           lnk
);
	import hu_pkg::*;
	logic [4:0]             s1;
	logic [4:0]             s2;
	logic [4:0]             s3;
	logic [4:0]             pin;
	logic [4:0]             pin_q;
	logic [15:0]            lf_cnt;
	logic                   lf_tick;
	logic [15:0]            ext_cnt;
	logic [7:0]             rst_cnt;
	logic                   ext_fire;
	logic                   int_req;
	logic                   chip_rst;
	logic [15:0]            blink_cnt;
	logic                   blink;
	logic                   link_q;
	logic [15:0]            baud_div;
	hu_frame_type           frame;
	logic [7:0]             tx_buf;
	logic                   tx_pend;
	logic                   tx_go;
	logic                   tx_busy;
	logic                   tx_busy_q;
	logic [7:0]             rx_data;
	logic                   rx_done;
	logic                   par_err;
	logic                   frm_err;
	logic [7:0]             rx_hold;
	logic                   rx_valid;
	logic [NUM_INT-1:0]     int_stat;
	logic [NUM_INT-1:0]     int_mask;
	logic [NUM_INT-1:0]     ev;
	logic                   acc;
	logic                   wr_pend;
	logic [7:0]             wr_addr;
	logic [31:0]            next_rdata;
	logic                   rd_rx;
	assign acc = i_hsel & i_htrans[1] & i_hready;
	assign rd_rx = acc & !i_hwrite & (i_haddr[7:0] == A_RXDATA);

	// three-stage pin synchroniser; a level counts once stages two and three agree
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s1 <= SYNC_RST;
			s2 <= SYNC_RST;
			s3 <= SYNC_RST;
			pin <= SYNC_RST;
			pin_q <= SYNC_RST;
		end
		else
		begin
			s1 <= {lnk.external_reset_n, lnk.link_drop_request, lnk.mode_select_pin, lnk.cts_n, lnk.host_txd};
			s2 <= s1;
			s3 <= s2;
			pin <= (s2 & ~(s2 ^ s3)) | (pin & (s2 ^ s3));
			pin_q <= pin;
		end
	end

	// low-frequency tick stands in for the slow oscillator
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			lf_cnt <= 16'h0000;
			lf_tick <= 1'b0;
		end
		else
		begin
			lf_tick <= (lf_cnt == 16'(LF_DIV - 1));
			lf_cnt <= (lf_cnt == 16'(LF_DIV - 1)) ? 16'h0000 : lf_cnt + 16'h0001;
		end
	end

	// reset pin must stay low for the filter delay before the chip resets
	assign ext_fire = !pin[4] & (ext_cnt == 16'(RST_TICKS));
	assign int_req = i_watchdog_reset | i_low_voltage_reset | i_core_system_reset_request
		| i_whole_chip_soft_reset;
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			ext_cnt <= 16'h0000;
		else if (pin[4])
			ext_cnt <= 16'h0000;
		else if (lf_tick && !ext_fire)
			ext_cnt <= ext_cnt + 16'h0001;
	end

	// each source reloads the pulse counter, so the pulse outlasts its cause
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_cnt <= 8'h00;
			chip_rst <= 1'b1;
			o_sys_reset <= 1'b1;
		end
		else
		begin
			if (ext_fire || int_req)
				rst_cnt <= 8'(RST_PULSE_CYC);
			else if (rst_cnt != 8'h00)
				rst_cnt <= rst_cnt - 8'h01;
			chip_rst <= ext_fire | int_req | (rst_cnt > 8'h01);
			o_sys_reset <= ext_fire | int_req | (rst_cnt > 8'h01);
		end
	end

	// link controls are only obeyed while linked
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			link_q <= 1'b0;
			o_link_drop <= 1'b0;
			o_transfer_mode_select <= 1'b0;
		end
		else
		begin
			link_q <= i_link_up;
			o_link_drop <= i_link_up & pin[3] & !pin_q[3] & !chip_rst;
			if (i_link_up)
				o_transfer_mode_select <= pin[2];
		end
	end

	// slow blink from the tick; steady once linked
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			blink_cnt <= 16'h0000;
			blink <= 1'b0;
		end
		else if (lf_tick)
		begin
			blink_cnt <= (blink_cnt == 16'(BLINK - 1)) ? 16'h0000 : blink_cnt + 16'h0001;
			if (blink_cnt == 16'(BLINK - 1))
				blink <= !blink;
		end
	end

	// pins let go during reset; undriven pins float up to the pull-up
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			lnk.rts_n <= 1'b1;
			lnk.rts_n_oe <= 1'b0;
			lnk.dev_txd_oe <= 1'b0;
			lnk.connection_state_out <= 1'b0;
			lnk.connection_state_oe <= 1'b0;
			lnk.link_indicator_out <= 1'b0;
			lnk.link_indicator_oe <= 1'b0;
		end
		else
		begin
			lnk.rts_n <= frame.flow & rx_valid;
			lnk.rts_n_oe <= !chip_rst;
			lnk.dev_txd_oe <= !chip_rst;
			lnk.connection_state_out <= i_link_up;
			lnk.connection_state_oe <= !chip_rst;
			lnk.link_indicator_out <= i_link_up | blink;
			lnk.link_indicator_oe <= !chip_rst;
		end
	end

	// character starts only with clear-to-send low when handshaking
	assign tx_go = tx_pend & !tx_busy & !(frame.flow & pin[1]);
	hu_serial u_serial (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_clr     (chip_rst),
		.i_div     (baud_div),
		.i_cfg     (frame),
		.i_tx_data (tx_buf),
		.i_tx_go   (tx_go),
		.o_txd     (lnk.dev_txd),
		.o_tx_busy (tx_busy),
		.i_rxd     (pin[0]),
		.o_rx_data (rx_data),
		.o_rx_done (rx_done),
		.o_par_err (par_err),
		.o_frm_err (frm_err)
	);

	// interrupt causes
	assign ev[I_RX] = rx_done;
	assign ev[I_TX] = tx_busy_q & !tx_busy;
	assign ev[I_PAR] = rx_done & par_err;
	assign ev[I_FRM] = rx_done & frm_err;
	assign ev[I_OVR] = rx_done & rx_valid & !rd_rx;
	assign ev[I_BRK] = rx_done & frm_err & (rx_data == 8'h00);
	assign ev[I_CTS] = pin[1] ^ pin_q[1];
	assign ev[I_UP] = i_link_up & !link_q;
	assign ev[I_DOWN] = !i_link_up & link_q;
	assign ev[I_DROP] = i_link_up & pin[3] & !pin_q[3];

	// register writes land in the data phase; set beats clear on the sticky bits
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			baud_div <= BAUD_DIV_RST;
			frame <= FRAME_RST;
			tx_buf <= 8'h00;
			tx_pend <= 1'b0;
			rx_hold <= 8'h00;
			rx_valid <= 1'b0;
			int_stat <= '0;
			int_mask <= '0;
			tx_busy_q <= 1'b0;
		end
		else if (chip_rst)
		begin
			wr_pend <= 1'b0;
			baud_div <= BAUD_DIV_RST;
			frame <= FRAME_RST;
			tx_pend <= 1'b0;
			rx_valid <= 1'b0;
			int_stat <= '0;
			int_mask <= '0;
			tx_busy_q <= 1'b0;
		end
		else
		begin
			wr_pend <= acc & i_hwrite;
			wr_addr <= i_haddr[7:0];
			tx_busy_q <= tx_busy;
			if (tx_go)
				tx_pend <= 1'b0;
			if (rx_done)
				rx_hold <= rx_data;
			rx_valid <= rx_done | (rx_valid & !rd_rx);
			int_stat <= ev | (int_stat & ~((wr_pend && wr_addr == A_INT_STAT) ? i_hwdata[NUM_INT-1:0] : '0));
			if (wr_pend)
			begin
				case (wr_addr)
					A_BAUD:     baud_div <= i_hwdata[15:0];
					A_FRAME:    frame <= i_hwdata[5:0];
					A_INT_MASK: int_mask <= i_hwdata[NUM_INT-1:0];
					A_TXDATA:
					begin
						tx_buf <= i_hwdata[7:0];
						tx_pend <= 1'b1;
					end
					default:    tx_buf <= tx_buf;
				endcase
			end
		end
	end

	// read data chosen in the address phase, presented in the data phase
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (i_haddr[7:0])
			A_BAUD:     next_rdata = {16'h0000, baud_div};
			A_FRAME:    next_rdata = {26'h0000000, frame};
			A_RXDATA:   next_rdata = {24'h000000, rx_hold};
			A_STATUS:   next_rdata = {27'h0000000, !pin[1], i_link_up, o_transfer_mode_select, rx_valid, tx_busy | tx_pend};
			A_INT_STAT: next_rdata = {22'h000000, int_stat};
			A_INT_MASK: next_rdata = {22'h000000, int_mask};
			default:    next_rdata = 32'h0000_0000;
		endcase
	end

	// zero-wait slave, always okay; interrupt level from the unmasked bits
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_hrdata <= 32'h0000_0000;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
			o_irq <= 1'b0;
		end
		else
		begin
			o_hrdata <= (acc && !i_hwrite) ? next_rdata : 32'h0000_0000;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
			o_irq <= |(int_stat & int_mask);
		end
	end
endmodule
`default_nettype wire

// ---- verilog/hu_pkg.sv ----
// hu_pkg: shared constants and types for the host serial and control port
`default_nettype none
// Overview of operation
// - linked: mode pin high command, low throughput
// - linked: disconnect pin rising edge drops link
// - indicator blinks slowly unlinked, steady when linked
// - connection status low unlinked, high linked
// - reset from power-on, pin, watchdog, voltage, software
// - filtered reset pin acts 1.5 to 4.0 ms later
// - host holds reset pin low over 5 ms
// - pin pulses up to 100 ns ignored, 300 ns taken
// - internal reset source gives pulse of 20 us minimum
// - during reset all device pins stop driving
// - full-duplex serial to parallel and back
// - serial controller offers ten interrupt causes
// - both handshake lines are active low
// - host stops sending while device request line deasserted
// - rate 1200 to 921600 bit/s, 115200 standard
// - parity none/odd/even, 1-2 stop, 5-8 data, handshake
// - request output and clear input are active low
package hu_pkg;
	// clock
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
	// reset timing
	localparam int unsigned RST_PULSE_US = 20;
	localparam int unsigned RST_PULSE_CYC = (RST_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned LF_HZ = 32768;
	localparam int unsigned LF_DIV_CYC = CLK_HZ / LF_HZ;
	localparam int unsigned RST_DLY_MIN_US = 1500;
	localparam int unsigned RST_DLY_MAX_US = 4000;
	localparam int unsigned RST_DLY_TICKS = ((RST_DLY_MIN_US + RST_DLY_MAX_US) / 2) * LF_HZ / 1_000_000;
	localparam int unsigned HOST_RST_MS = 5;
	localparam int unsigned HOST_RST_CYC = HOST_RST_MS * 1_000_000 / CLK_NS + 1;
	localparam int unsigned BLINK_TICKS = LF_HZ / 2;
	localparam logic [3:0] DROP_HIGH_CYC = 4'h4;
	// serial rate, bit period is divisor plus one cycles
	localparam int unsigned BAUD_STD = 115200;
	localparam logic [15:0] BAUD_DIV_RST = 16'((CLK_HZ + BAUD_STD / 2) / BAUD_STD - 1);
	// register offsets
	localparam logic [7:0] A_BAUD = 8'h00;
	localparam logic [7:0] A_FRAME = 8'h04;
	localparam logic [7:0] A_TXDATA = 8'h08;
	localparam logic [7:0] A_RXDATA = 8'h0c;
	localparam logic [7:0] A_STATUS = 8'h10;
	localparam logic [7:0] A_INT_STAT = 8'h14;
	localparam logic [7:0] A_INT_MASK = 8'h18;
	// interrupt cause positions
	localparam int unsigned NUM_INT = 10;
	localparam int unsigned I_RX = 0;
	localparam int unsigned I_TX = 1;
	localparam int unsigned I_PAR = 2;
	localparam int unsigned I_FRM = 3;
	localparam int unsigned I_OVR = 4;
	localparam int unsigned I_BRK = 5;
	localparam int unsigned I_CTS = 6;
	localparam int unsigned I_UP = 7;
	localparam int unsigned I_DOWN = 8;
	localparam int unsigned I_DROP = 9;
	// pin synchroniser order {reset_n, drop, mode, cts_n, rxd}
	localparam logic [4:0] SYNC_RST = 5'h13;
	// frame format, len holds data bits minus five
	typedef struct packed {
		logic       flow;
		logic       stop2;
		logic       par_odd;
		logic       par_en;
		logic [1:0] len;
	} hu_frame_type;
	localparam logic [5:0] FRAME_RST = 6'h03;
	// bit sequencer states
	typedef enum logic [2:0] {
		HU_IDLE   = 3'h0,
		HU_START  = 3'h1,
		HU_DATA   = 3'h3,
		HU_PARITY = 3'h2,
		HU_STOP   = 3'h6
	} hu_bit_state_type;
endpackage
`default_nettype wire

// ---- verilog/hu_link_if.sv ----
// hu_link_if: serial and control pins between device and host
`default_nettype none
interface hu_link_if;
	// device pins, value and enable
	logic dev_txd;
	logic dev_txd_oe;
	logic rts_n;
	logic rts_n_oe;
	logic connection_state_out;
	logic connection_state_oe;
	logic link_indicator_out;
	logic link_indicator_oe;
	// host pins, always driven
	logic host_txd;
	logic cts_n;
	logic mode_select_pin;
	logic link_drop_request;
	logic external_reset_n;
	// wire levels, weak pull-up while the device lets go
	logic txd_lvl;
	logic rts_n_lvl;
	logic state_lvl;
	logic indicator_lvl;
	assign txd_lvl = dev_txd_oe ? dev_txd : 1'b1;
	assign rts_n_lvl = rts_n_oe ? rts_n : 1'b1;
	assign state_lvl = connection_state_oe ? connection_state_out : 1'b1;
	assign indicator_lvl = link_indicator_oe ? link_indicator_out : 1'b1;
	modport dev (
		output dev_txd, dev_txd_oe, rts_n, rts_n_oe, connection_state_out, connection_state_oe,
		output link_indicator_out, link_indicator_oe,
		input  host_txd, cts_n, mode_select_pin, link_drop_request, external_reset_n
	);
	modport host (
		output host_txd, cts_n, mode_select_pin, link_drop_request, external_reset_n,
		input  txd_lvl, rts_n_lvl, state_lvl, indicator_lvl
	);
endinterface
`default_nettype wire

// ---- verilog/hu_host.sv ----
// hu_host: host end driving the serial and control pins
`default_nettype none
module hu_host
#(
	parameter int unsigned RST_HOLD = hu_pkg::HOST_RST_CYC
)
(
	// clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	// serial settings
	input  wire logic [15:0]          i_div,
	input  wire hu_pkg::hu_frame_type i_cfg,
	// transmit stream
	input  wire logic [7:0]           i_tx_data,
	input  wire logic                 i_tx_valid,
	output logic                      o_tx_ready,
	// receive stream
	output logic [7:0]                o_rx_data,
	output logic                      o_rx_valid,
	output logic                      o_rx_err,
	// control
	input  wire logic                 i_cmd_mode,
	input  wire logic                 i_drop_req,
	input  wire logic                 i_reset_req,
	input  wire logic                 i_rx_hold,
	// status
	output logic                      o_link_up,
	output logic                      o_indicator,
	output logic                      o_device_rts,
	// pins toward the device
	hu_link_if.host                   lnk
);
	import hu_pkg::*;
	logic [3:0]  s1;
	logic [3:0]  s2;
	logic [3:0]  s3;
	logic [3:0]  pin;
	logic        tx_go;
	logic        tx_busy;
	logic        par_err;
	logic        frm_err;
	logic [3:0]  drop_cnt;
	logic [19:0] rst_cnt;
	assign tx_go = i_tx_valid & o_tx_ready;

	// device pins cross in through three flops {state, indicator, rts_n, txd}
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s1 <= 4'h3;
			s2 <= 4'h3;
			s3 <= 4'h3;
			pin <= 4'h3;
		end
		else
		begin
			s1 <= {lnk.state_lvl, lnk.indicator_lvl, lnk.rts_n_lvl, lnk.txd_lvl};
			s2 <= s1;
			s3 <= s2;
			pin <= (s2 & ~(s2 ^ s3)) | (pin & (s2 ^ s3));
		end
	end

	// with handshaking on, a character starts only while the device requests data
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_tx_ready <= 1'b0;
			o_link_up <= 1'b0;
			o_indicator <= 1'b0;
			o_device_rts <= 1'b0;
		end
		else
		begin
			o_tx_ready <= !tx_busy & !tx_go & !(i_cfg.flow & pin[1]);
			o_link_up <= pin[3];
			o_indicator <= pin[2];
			o_device_rts <= !pin[1];
		end
	end

	// control pins: mode level, widened drop pulse, long reset hold
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			lnk.cts_n <= 1'b1;
			lnk.mode_select_pin <= 1'b0;
			lnk.link_drop_request <= 1'b0;
			lnk.external_reset_n <= 1'b1;
			drop_cnt <= 4'h0;
			rst_cnt <= 20'h00000;
		end
		else
		begin
			lnk.cts_n <= i_cfg.flow & i_rx_hold;
			lnk.mode_select_pin <= i_cmd_mode;
			if (i_drop_req && drop_cnt == 4'h0)
				drop_cnt <= DROP_HIGH_CYC;
			else if (drop_cnt != 4'h0)
				drop_cnt <= drop_cnt - 4'h1;
			lnk.link_drop_request <= drop_cnt != 4'h0;
			if (i_reset_req && rst_cnt == 20'h00000)
				rst_cnt <= 20'(RST_HOLD);
			else if (rst_cnt != 20'h00000)
				rst_cnt <= rst_cnt - 20'h00001;
			lnk.external_reset_n <= rst_cnt == 20'h00000;
		end
	end

	// received errors reported with the character
	assign o_rx_err = par_err | frm_err;
	hu_serial u_serial (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_clr     (1'b0),
		.i_div     (i_div),
		.i_cfg     (i_cfg),
		.i_tx_data (i_tx_data),
		.i_tx_go   (tx_go),
		.o_txd     (lnk.host_txd),
		.o_tx_busy (tx_busy),
		.i_rxd     (pin[0]),
		.o_rx_data (o_rx_data),
		.o_rx_done (o_rx_valid),
		.o_par_err (par_err),
		.o_frm_err (frm_err)
	);
endmodule
`default_nettype wire

// ---- dv/hu_asserts.sv ----
// hu_asserts: timing checks on the pins between device and host
`default_nettype none
module hu_asserts
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// pins
	input wire logic dev_txd,
	input wire logic dev_txd_oe,
	input wire logic rts_n_oe,
	input wire logic connection_state_out,
	input wire logic connection_state_oe,
	input wire logic link_indicator_out,
	input wire logic link_indicator_oe,
	input wire logic host_txd,
	input wire logic link_drop_request,
	input wire logic external_reset_n
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// drop pin: four high cycles, then low
	sequence s_drop_high;
		link_drop_request [*4] ##1 !link_drop_request;
	endsequence
	// pins are released and taken back as one group, so no pin floats alone
	a_oe_group: assert property (dev_txd_oe == rts_n_oe && dev_txd_oe == connection_state_oe
		&& dev_txd_oe == link_indicator_oe) else $error("pin enables split");
	a_idle_on_enable: assert property ($rose(dev_txd_oe) |-> dev_txd) else $error("txd not idle");
	// bench runs four cycles a bit, so a level holds three more edges
	a_dev_bit_len: assert property ($changed(dev_txd) && dev_txd_oe |=>
		($stable(dev_txd) || !dev_txd_oe) [*3]) else $error("device bit short");
	a_host_bit_len: assert property ($changed(host_txd) |=> $stable(host_txd) [*3]) else $error("host bit short");
	a_drop_width: assert property ($rose(link_drop_request) |-> s_drop_high) else $error("drop width");
	a_rst_hold: assert property ($fell(external_reset_n) |-> !external_reset_n [*8]) else $error("reset short");
	a_pin_rst_off: assert property ($fell(external_reset_n) ##40 !external_reset_n |-> !dev_txd_oe)
		else $error("pin reset late");
	a_rst_pulse: assert property ($rose(external_reset_n) |=> !dev_txd_oe [*8]) else $error("reset pulse short");
	a_lit_linked: assert property (connection_state_out && $past(connection_state_out, 3) && link_indicator_oe
		|-> link_indicator_out) else $error("lamp not steady");
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// tb: device and host ends joined, device reached over the bus
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import hu_pkg::*;
	logic         clk, rst_n, hwrite, hrdy, hresp, tx_valid, cmd, drop, rreq, link, sysr, ldrop, irq, mode;
	logic         h_ready, h_rxv, h_err, h_up, h_ind, hold, hsel = 1'b1;
	logic [1:0]   htrans;
	logic [3:0]   rsrc, ev;
	logic [5:0]   f;
	logic [7:0]   tx_data, h_rx;
	logic [15:0]  div;
	logic [31:0]  haddr, hwdata, hrdata, q;
	hu_frame_type cfg;
	int           error_cnt = 0, num_checks = 0, i;
	assign ev = {sysr, ldrop, h_rxv, irq};
	hu_link_if lnk ();
	// short counts keep the reset and blink waits within a few cycles
	hu_device #(.LF_DIV(4), .RST_TICKS(5), .BLINK(4)) i_hu_device (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
		.o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .i_watchdog_reset(rsrc[0]),
		.i_low_voltage_reset(rsrc[1]), .i_core_system_reset_request(rsrc[2]), .i_whole_chip_soft_reset(rsrc[3]),
		.o_sys_reset(sysr), .i_link_up(link), .o_link_drop(ldrop), .o_transfer_mode_select(mode), .o_irq(irq),
		.lnk(lnk));
	hu_host #(.RST_HOLD(60)) i_hu_host (.i_clk(clk), .i_rst_n(rst_n), .i_div(div), .i_cfg(cfg), .i_tx_data(tx_data),
		.i_tx_valid(tx_valid), .o_tx_ready(h_ready), .o_rx_data(h_rx), .o_rx_valid(h_rxv), .o_rx_err(h_err),
		.i_cmd_mode(cmd), .i_drop_req(drop), .i_reset_req(rreq), .i_rx_hold(hold), .o_link_up(h_up),
		.o_indicator(h_ind), .o_device_rts(), .lnk(lnk));
	hu_asserts i_hu_asserts (.i_clk(clk), .i_rst_n(rst_n), .dev_txd(lnk.dev_txd), .dev_txd_oe(lnk.dev_txd_oe),
		.rts_n_oe(lnk.rts_n_oe), .connection_state_out(lnk.connection_state_out),
		.connection_state_oe(lnk.connection_state_oe), .link_indicator_out(lnk.link_indicator_out),
		.link_indicator_oe(lnk.link_indicator_oe), .host_txd(lnk.host_txd),
		.link_drop_request(lnk.link_drop_request), .external_reset_n(lnk.external_reset_n));
	// clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task finish_test;
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	// one single transfer; read data is taken at the data phase edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		q = hrdata;
	endtask
	task rd(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, e, q);
	endtask
	// bounded wait for one event line
	task wt(input int b, input int n);
		int k;
		for (k = 0; k < n && ev[b] !== 1'b1; k++) @(posedge clk);
		chk("event", 32'h1, ev[b]);
	endtask
	// hang guard, far above the fewer than two thousand cycles the run needs
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test;
	end
	initial
	begin
		{rst_n, hold, hwrite, tx_valid, cmd, drop, rreq, link, htrans, rsrc, haddr, hwdata, tx_data} = '0;
		div = BAUD_DIV_RST;
		cfg = FRAME_RST;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd("baud", A_BAUD, {16'h0, BAUD_DIV_RST});
		rd("unmapped", 8'h1c, 32'h0);
		bus(1'b1, A_BAUD, 32'h3);
		hsel <= 1'b0;
		bus(1'b1, A_BAUD, 32'h5);
		hsel <= 1'b1;
		rd("desel", A_BAUD, 32'h3);
		bus(1'b1, A_INT_MASK, 32'h1);
		div <= 16'h3;
		// 8 bits even parity one stop, then 5 bits odd parity two stops, flow
		for (i = 0; i < 2; i++)
		begin
			f = i ? 6'h3c : 6'h07;
			bus(1'b1, A_FRAME, {26'h0, f});
			cfg <= f;
			hold <= f[5];
			tx_data <= 8'ha5;
			tx_valid <= 1'b1;
			@(posedge clk);
			while (h_ready !== 1'b1) @(posedge clk);
			tx_valid <= 1'b0;
			wt(0, 300);
			rd("rx byte", A_RXDATA, i ? 32'h05 : 32'ha5);
			bus(1'b1, A_INT_STAT, 32'h1);
			bus(1'b0, A_INT_STAT, 32'h0);
			chk("rx cause", 32'h0, q[0]);
			chk("irq", 32'h0, irq);
			bus(1'b1, A_TXDATA, 32'h3c);
			if (i)
			begin
				repeat (60) @(posedge clk);
				rd("held", A_STATUS, 32'h1);
				hold <= 1'b0;
			end
			wt(1, 300);
			chk("host rx", i ? 32'h1c : 32'h3c, h_rx);
			chk("host err", 32'h0, h_err);
		end
		q[0] = h_ind;
		repeat (16) @(posedge clk);
		chk("lamp blink", {31'h0, ~q[0]}, h_ind);
		link <= 1'b1;
		cmd <= 1'b1;
		repeat (10) @(posedge clk);
		chk("linked", 32'h1, h_up);
		chk("lamp on", 32'h1, h_ind);
		chk("mode", 32'h1, mode);
		drop <= 1'b1;
		@(posedge clk);
		drop <= 1'b0;
		wt(2, 20);
		link <= 1'b0;
		cmd <= 1'b0;
		repeat (10) @(posedge clk);
		chk("unlinked", 32'h0, h_up);
		chk("mode held", 32'h1, mode);
		// each internal source: pulse stays up 200 cycles, registers restored
		for (i = 0; i < 4; i++)
		begin
			rsrc <= 4'h1 << i;
			@(posedge clk);
			rsrc <= 4'h0;
			repeat (150) @(posedge clk);
			chk("sys reset", 32'h1, sysr);
			repeat (80) @(posedge clk);
			rd("baud again", A_BAUD, {16'h0, BAUD_DIV_RST});
		end
		rreq <= 1'b1;
		@(posedge clk);
		rreq <= 1'b0;
		wt(3, 60);
		repeat (300) @(posedge clk);
		finish_test;
	end
endmodule
`default_nettype wire
